// >>> inc/tac_pkg.sv
`default_nettype none

package tac_pkg;

  // Register bus geometry
  localparam int unsigned WB_ADR_W = 8;
  localparam int unsigned WB_DAT_W = 32;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h0C;

  // Control register fields
  localparam int unsigned CTRL_WD_LSB = 0;
  localparam int unsigned CTRL_WD_W = 4;
  localparam int unsigned CTRL_TRACK_BIT = 4;
  localparam int unsigned CTRL_IDF_BIT = 5;
  localparam int unsigned CTRL_AF_BIT = 6;
  localparam int unsigned CTRL_DIRTY_BIT = 7;
  localparam int unsigned CTRL_W = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_00F0;

  // Status register fields
  localparam int unsigned STAT_ACTIVE_BIT = 0;
  localparam int unsigned STAT_CAUSE_LSB = 1;
  localparam int unsigned STAT_COUNT_LSB = 8;

  // Interrupt status and mask fields
  localparam int unsigned IRQ_ERR_BIT = 0;
  localparam int unsigned IRQ_IMP_BIT = 1;
  localparam int unsigned IRQ_MEM_BIT = 2;
  localparam int unsigned IRQ_OVF_BIT = 3;
  localparam int unsigned IRQ_W = 4;
  localparam logic [31:0] IRQ_MASK_RST = 32'h0000_0000;

  // Failure word written to the start instruction destination
  localparam int unsigned FW_MEM_BIT = 17;
  localparam int unsigned FW_RTRY_BIT = 15;
  localparam int unsigned FW_ERR_BIT = 20;
  localparam int unsigned FW_IMP_BIT = 24;

  typedef enum logic [1:0] {
    CAUSE_NONE = 2'b00,
    CAUSE_IMP = 2'b01,
    CAUSE_ERR = 2'b10,
    CAUSE_MEM = 2'b11
  } fail_cause_t;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_ACTIVE = 1'b1
  } tx_state_t;

endpackage : tac_pkg

`default_nettype wire

// >>> rtl/mapping_tracker.sv
`timescale 1ns/100ps
`default_nettype none

module mapping_tracker #(
  parameter int unsigned ENTRIES = 8,
  parameter int unsigned PAGE_W = 36,
  parameter int unsigned CNT_W = $clog2(ENTRIES + 1)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic add_i,
  input wire logic [PAGE_W-1:0] add_page_i,
  input wire logic inv_i,
  input wire logic inv_all_i,
  input wire logic [PAGE_W-1:0] inv_page_i,
  output logic hit_o,
  output logic overflow_o,
  output logic [CNT_W-1:0] count_o
);

  logic [ENTRIES-1:0] valid_ff;
  logic [ENTRIES-1:0] nxt_valid;
  logic [PAGE_W-1:0] page_ff [ENTRIES];
  logic [PAGE_W-1:0] nxt_page [ENTRIES];
  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] nxt_count;
  logic [ENTRIES-1:0] present;
  logic [ENTRIES-1:0] match;
  logic full;
  logic insert;

  // Per entry compare
  for (genvar g = 0; g < ENTRIES; g++)
  begin : g_entry
    assign present[g] = valid_ff[g] && (page_ff[g] == add_page_i);
    assign match[g] = valid_ff[g] && (inv_all_i || (page_ff[g] == inv_page_i));
  end

  assign full = (count_ff == CNT_W'(ENTRIES));
  assign insert = add_i && !(|present) && !full;
  assign hit_o = inv_i && (|match);
  // [RULE10] Tracking limit exceeded
  assign overflow_o = add_i && !(|present) && full;
  assign count_o = count_ff;

  always_comb
  begin
    nxt_valid = valid_ff;
    nxt_page = page_ff;
    nxt_count = count_ff;
    if (clear_i)
    begin
      nxt_valid = '0;
      nxt_count = '0;
    end
    else if (insert)
    begin
      for (int i = 0; i < ENTRIES; i++)
      begin
        if (count_ff == CNT_W'(i))
        begin
          nxt_valid[i] = 1'b1;
          nxt_page[i] = add_page_i;
        end
      end
      nxt_count = count_ff + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      valid_ff <= '0;
      count_ff <= '0;
      for (int i = 0; i < ENTRIES; i++)
      begin
        page_ff[i] <= '0;
      end
    end
    else
    begin
      valid_ff <= nxt_valid;
      count_ff <= nxt_count;
      page_ff <= nxt_page;
    end
  end

endmodule : mapping_tracker

`default_nettype wire

// >>> rtl/transactional_access_checker.sv
// Functional notes
// [RULE1] Unsupported memory fails with implementation cause
// [RULE2] Guaranteed write-back shareable memory always allowed
// [RULE3] System input selects further supported ranges
// [RULE4] User walks blocked by per-base disable bits
// [RULE5] Blocked or faulting access fails, no exception
// [RULE6] Hardware access flag and dirty updates
// [RULE7] Access flag updates survive failure
// [RULE8] Dirty updates survive failure
// [RULE9] Remote invalidation of tracked location fails
// [RULE10] Track mappings or fail; overflow fails
// [RULE11] Mismatched ids may be ignored
// [RULE12] Mixed shareability across instructions accepted
// [RULE13] Software avoids mixed shareability per instruction
// [RULE14] Instruction stream not isolated
// [RULE15] Transactional stores hidden until commit
// [RULE16] Failed stores never written out
// [RULE17] Destination receives failure cause encoding
// [RULE18] One failure pulse, one cause, same cycle
`timescale 1ns/100ps
`default_nettype none

module transactional_access_checker
  import tac_pkg::*;
#(
  parameter int unsigned ENTRIES = 8,
  parameter int unsigned PAGE_W = 36,
  parameter int unsigned ID_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [WB_DAT_W-1:0] wb_dat_i,
  output logic [WB_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic tx_start_i,
  input wire logic tx_commit_i,
  input wire logic tx_cancel_i,
  input wire logic [ID_W-1:0] cur_address_space_id_i,
  input wire logic [ID_W-1:0] cur_virtual_machine_id_i,
  input wire logic acc_valid_i,
  input wire logic acc_store_i,
  input wire logic acc_user_i,
  input wire logic acc_hyp_regime_i,
  input wire logic acc_high_range_i,
  input wire logic acc_tlb_miss_i,
  input wire logic acc_would_fault_i,
  input wire logic [PAGE_W-1:0] acc_page_i,
  input wire logic acc_normal_i,
  input wire logic acc_inner_share_i,
  input wire logic acc_outer_share_i,
  input wire logic acc_inner_wb_i,
  input wire logic acc_outer_wb_i,
  input wire logic acc_read_alloc_i,
  input wire logic acc_write_alloc_i,
  input wire logic acc_transient_i,
  input wire logic sys_tx_allowed_i,
  input wire logic acc_af_needed_i,
  input wire logic acc_dirty_needed_i,
  input wire logic inv_valid_i,
  input wire logic inv_all_i,
  input wire logic [PAGE_W-1:0] inv_page_i,
  input wire logic [ID_W-1:0] inv_address_space_id_i,
  input wire logic [ID_W-1:0] inv_virtual_machine_id_i,
  output logic tx_active_o,
  output logic fail_o,
  output fail_cause_t fail_cause_o,
  output logic dest_wr_o,
  output logic [31:0] dest_val_o,
  output logic walk_ok_o,
  output logic exception_o,
  output logic store_visible_o,
  output logic store_release_o,
  output logic store_discard_o,
  output logic af_update_o,
  output logic dirty_update_o
);

  localparam int unsigned CNT_W = $clog2(ENTRIES + 1);

  tx_state_t tx_state_ff;
  tx_state_t nxt_tx_state;
  fail_cause_t last_cause_ff;
  fail_cause_t nxt_last_cause;
  fail_cause_t cause;
  logic [CTRL_W-1:0] ctrl_ff;
  logic [CTRL_W-1:0] nxt_ctrl;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] nxt_irq_stat;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic [IRQ_W-1:0] nxt_irq_mask;
  logic ack_ff;
  logic nxt_ack;
  logic [31:0] rdat_ff;
  logic [31:0] nxt_rdat;
  logic dest_wr_ff;
  logic nxt_dest_wr;
  logic [31:0] dest_val_ff;
  logic [31:0] nxt_dest_val;
  logic [31:0] bmask;
  logic [31:0] wmask;
  logic [IRQ_W-1:0] events;
  logic [CTRL_WD_W-1:0] wd_bits;
  logic [CNT_W-1:0] trk_count;
  logic tx_in;
  logic acc_tx;
  logic guaranteed;
  logic supported;
  logic walk_blocked;
  logic err_hit;
  logic imp_hit;
  logic mem_hit;
  logic ovf_hit;
  logic trk_hit;
  logic ids_differ;
  logic inv_counts;
  logic trk_clear;
  logic wb_req;
  logic wb_wr;

  assign tx_in = (tx_state_ff == TX_ACTIVE);
  assign acc_tx = acc_valid_i && tx_in;
  assign wd_bits = ctrl_ff[CTRL_WD_LSB +: CTRL_WD_W];

  // [RULE2] Guaranteed memory types
  assign guaranteed = acc_normal_i && (acc_inner_share_i || acc_outer_share_i)
    && acc_inner_wb_i && acc_outer_wb_i && acc_read_alloc_i && acc_write_alloc_i
    && !acc_transient_i;
  // [RULE3] System range selection
  assign supported = guaranteed || sys_tx_allowed_i;
  // [RULE1] Unsupported type fails
  assign imp_hit = acc_tx && !supported;

  // [RULE4] Per base walk disable
  assign walk_blocked = acc_user_i && wd_bits[{acc_hyp_regime_i, acc_high_range_i}];
  // [RULE5] Error instead of exception
  assign err_hit = acc_tx && ((walk_blocked && acc_tlb_miss_i) || acc_would_fault_i);
  assign walk_ok_o = acc_valid_i && acc_tlb_miss_i && !(tx_in && walk_blocked);
  assign exception_o = acc_valid_i && acc_would_fault_i && !tx_in;

  // [RULE12] Shareability mix not checked
  // [RULE14] Only data mappings tracked
  mapping_tracker #(
    .ENTRIES(ENTRIES),
    .PAGE_W(PAGE_W),
    .CNT_W(CNT_W)
  ) u_tracker (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(trk_clear),
    .add_i(acc_tx && ctrl_ff[CTRL_TRACK_BIT]),
    .add_page_i(acc_page_i),
    .inv_i(inv_valid_i),
    .inv_all_i(inv_all_i),
    .inv_page_i(inv_page_i),
    .hit_o(trk_hit),
    .overflow_o(ovf_hit),
    .count_o(trk_count)
  );

  assign trk_clear = !tx_in || (nxt_tx_state == TX_IDLE);

  // [RULE11] Foreign id filter
  assign ids_differ = (inv_address_space_id_i != cur_address_space_id_i) || (inv_virtual_machine_id_i != cur_virtual_machine_id_i);
  assign inv_counts = inv_valid_i && !(ctrl_ff[CTRL_IDF_BIT] && ids_differ && !inv_all_i);
  // [RULE9] Remote invalidation hit
  // [RULE10] Untracked mode fails on any invalidation the id filter passes
  assign mem_hit = tx_in && inv_counts && (!ctrl_ff[CTRL_TRACK_BIT] || trk_hit);

  // [RULE18] Single cause by priority
  always_comb
  begin
    if (err_hit)
    begin
      cause = CAUSE_ERR;
    end
    else if (imp_hit || ovf_hit)
    begin
      cause = CAUSE_IMP;
    end
    else if (mem_hit)
    begin
      cause = CAUSE_MEM;
    end
    else
    begin
      cause = CAUSE_NONE;
    end
  end

  assign fail_o = (cause != CAUSE_NONE);
  assign fail_cause_o = cause;
  assign tx_active_o = tx_in;

  // [RULE15] Hold stores until commit
  assign store_visible_o = acc_valid_i && acc_store_i && !tx_in;
  assign store_release_o = tx_in && tx_commit_i && !tx_cancel_i && !fail_o;
  // [RULE16] Discard on fail or cancel
  assign store_discard_o = tx_in && (fail_o || tx_cancel_i);

  // [RULE6] Hardware flag management
  // [RULE7] Access flag not rolled back
  assign af_update_o = acc_valid_i && ctrl_ff[CTRL_AF_BIT] && acc_af_needed_i
    && !(tx_in && walk_blocked && acc_tlb_miss_i);
  // [RULE8] Dirty state not rolled back
  assign dirty_update_o = acc_valid_i && acc_store_i && ctrl_ff[CTRL_DIRTY_BIT]
    && acc_dirty_needed_i && !(tx_in && walk_blocked && acc_tlb_miss_i);

  // Transaction state and failure word
  always_comb
  begin
    nxt_tx_state = tx_state_ff;
    nxt_last_cause = last_cause_ff;
    nxt_dest_wr = 1'b0;
    nxt_dest_val = dest_val_ff;
    case (tx_state_ff)
      TX_IDLE:
      begin
        if (tx_start_i)
        begin
          nxt_tx_state = TX_ACTIVE;
        end
      end
      TX_ACTIVE:
      begin
        if (fail_o || tx_commit_i || tx_cancel_i)
        begin
          nxt_tx_state = TX_IDLE;
        end
      end
      default:
      begin
        nxt_tx_state = TX_IDLE;
      end
    endcase
    // [RULE17] Failure cause encoding
    if (fail_o)
    begin
      nxt_last_cause = cause;
      nxt_dest_wr = 1'b1;
      nxt_dest_val = 32'h0000_0000;
      case (cause)
        CAUSE_ERR: nxt_dest_val[FW_ERR_BIT] = 1'b1;
        CAUSE_IMP: nxt_dest_val[FW_IMP_BIT] = 1'b1;
        CAUSE_MEM:
        begin
          nxt_dest_val[FW_MEM_BIT] = 1'b1;
          nxt_dest_val[FW_RTRY_BIT] = 1'b1;
        end
        default: nxt_dest_val = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_state_ff <= TX_IDLE;
      last_cause_ff <= CAUSE_NONE;
      dest_wr_ff <= 1'b0;
      dest_val_ff <= 32'h0000_0000;
    end
    else
    begin
      tx_state_ff <= nxt_tx_state;
      last_cause_ff <= nxt_last_cause;
      dest_wr_ff <= nxt_dest_wr;
      dest_val_ff <= nxt_dest_val;
    end
  end

  assign dest_wr_o = dest_wr_ff;
  assign dest_val_o = dest_val_ff;

  // Register bus slave
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wb_wr = wb_req && wb_we_i;
  assign bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wmask = wb_dat_i & bmask;

  assign events[IRQ_ERR_BIT] = (cause == CAUSE_ERR);
  assign events[IRQ_IMP_BIT] = imp_hit && !err_hit;
  assign events[IRQ_MEM_BIT] = (cause == CAUSE_MEM);
  assign events[IRQ_OVF_BIT] = ovf_hit && !err_hit;

  always_comb
  begin
    nxt_ack = wb_req;
    nxt_ctrl = ctrl_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_irq_stat = irq_stat_ff;
    nxt_rdat = 32'h0000_0000;
    if (wb_wr && (wb_adr_i == CTRL_OFF))
    begin
      nxt_ctrl = (ctrl_ff & ~bmask[CTRL_W-1:0]) | wmask[CTRL_W-1:0];
    end
    if (wb_wr && (wb_adr_i == IRQ_MASK_OFF))
    begin
      nxt_irq_mask = (irq_mask_ff & ~bmask[IRQ_W-1:0]) | wmask[IRQ_W-1:0];
    end
    if (wb_wr && (wb_adr_i == IRQ_STAT_OFF))
    begin
      nxt_irq_stat = irq_stat_ff & ~wmask[IRQ_W-1:0];
    end
    // Set wins over clear
    nxt_irq_stat = nxt_irq_stat | events;
    if (wb_req && !wb_we_i)
    begin
      case (wb_adr_i)
        CTRL_OFF: nxt_rdat[CTRL_W-1:0] = ctrl_ff;
        STATUS_OFF:
        begin
          nxt_rdat[STAT_ACTIVE_BIT] = tx_in;
          nxt_rdat[STAT_CAUSE_LSB +: 2] = last_cause_ff;
          nxt_rdat[STAT_COUNT_LSB +: CNT_W] = trk_count;
        end
        IRQ_STAT_OFF: nxt_rdat[IRQ_W-1:0] = irq_stat_ff;
        IRQ_MASK_OFF: nxt_rdat[IRQ_W-1:0] = irq_mask_ff;
        default: nxt_rdat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
      ctrl_ff <= CTRL_RST[CTRL_W-1:0];
      irq_stat_ff <= '0;
      irq_mask_ff <= IRQ_MASK_RST[IRQ_W-1:0];
    end
    else
    begin
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
      ctrl_ff <= nxt_ctrl;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign irq_o = |(irq_stat_ff & irq_mask_ff);

endmodule : transactional_access_checker

`default_nettype wire

// >>> verification/tac_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module tac_monitor
  import tac_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_ack_o,
  input wire logic tx_start_i,
  input wire logic tx_active_o,
  input wire logic acc_valid_i,
  input wire logic acc_user_i,
  input wire logic acc_store_i,
  input wire logic acc_would_fault_i,
  input wire logic acc_tlb_miss_i,
  input wire logic store_discard_o,
  input wire logic fail_o,
  input wire fail_cause_t fail_cause_o,
  input wire logic dest_wr_o,
  input wire logic [31:0] dest_val_o,
  input wire logic walk_ok_o,
  input wire logic exception_o,
  input wire logic store_visible_o,
  input wire logic store_release_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_cause_with_fail: assert property (fail_o == (fail_cause_o != CAUSE_NONE))
    else $error("failure pulse and cause disagree");
  a_fail_ends_tx: assert property (fail_o |=> !tx_active_o && dest_wr_o)
    else $error("failure did not end transaction and write destination");
  a_dest_imp_word: assert property (fail_o && fail_cause_o == CAUSE_IMP |=>
    dest_val_o[FW_IMP_BIT] && !dest_val_o[FW_MEM_BIT])
    else $error("implementation cause word wrong");
  a_dest_mem_word: assert property (fail_o && fail_cause_o == CAUSE_MEM |=>
    dest_val_o[FW_MEM_BIT] && dest_val_o[FW_RTRY_BIT])
    else $error("conflict cause word wrong");
  a_fault_err_cause: assert property (tx_active_o && acc_valid_i && acc_would_fault_i |->
    fail_o && fail_cause_o == CAUSE_ERR && !exception_o)
    else $error("faulting access not failed with error cause");
  a_no_tx_exception: assert property (tx_active_o && acc_valid_i |-> !exception_o)
    else $error("exception raised inside transaction");
  a_store_hidden: assert property (tx_active_o && acc_valid_i && acc_store_i |->
    !store_visible_o)
    else $error("transactional store made visible");
  a_fail_no_release: assert property (fail_o |-> !store_release_o)
    else $error("failed transaction released stores");
  a_fail_discards: assert property (fail_o |-> store_discard_o)
    else $error("failed transaction kept its stores");
  a_kernel_walk_ok: assert property (acc_valid_i && acc_tlb_miss_i && !acc_user_i |->
    walk_ok_o)
    else $error("kernel access denied a walk");
  a_start_enters: assert property (!tx_active_o && tx_start_i |=> tx_active_o)
    else $error("start did not enter transaction");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  c_fail_imp: cover property (fail_o && fail_cause_o == CAUSE_IMP);
  c_fail_err: cover property (fail_o && fail_cause_o == CAUSE_ERR);
  c_fail_mem: cover property (fail_o && fail_cause_o == CAUSE_MEM);
endmodule : tac_monitor
`default_nettype wire

// >>> verification/tac_remote_pe.sv
`timescale 1ns/100ps
`default_nettype none
module tac_remote_pe (
  input wire logic clk_i,
  input wire logic rq_i,
  input wire logic rq_all_i,
  input wire logic [35:0] rq_page_i,
  input wire logic [15:0] rq_address_space_id_i,
  input wire logic [15:0] rq_virtual_machine_id_i,
  output logic inv_valid_o,
  output logic inv_all_o,
  output logic [35:0] inv_page_o,
  output logic [15:0] inv_address_space_id_o,
  output logic [15:0] inv_virtual_machine_id_o
);
  always @(posedge clk_i)
  begin
    inv_valid_o <= rq_i;
    inv_all_o <= rq_i & rq_all_i;
    inv_page_o <= rq_i ? rq_page_i : ~rq_page_i;
    inv_address_space_id_o <= rq_i ? rq_address_space_id_i : ~rq_address_space_id_i;
    inv_virtual_machine_id_o <= rq_i ? rq_virtual_machine_id_i : ~rq_virtual_machine_id_i;
  end
endmodule : tac_remote_pe
`default_nettype wire

// >>> verification/transactional_access_checker_tb.sv
`timescale 1ns/100ps
`default_nettype none
module transactional_access_checker_tb;
  import tac_pkg::*;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, rq = 0, rq_all = 0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, dest_val_o;
  logic wb_ack_o, irq_o, tx_active_o, fail_o, dest_wr_o, walk_ok_o, exception_o;
  logic store_visible_o, store_release_o, store_discard_o, af_update_o, dirty_update_o;
  fail_cause_t fail_cause_o;
  logic tx_start_i = 0, tx_commit_i = 0, tx_cancel_i = 0, acc_valid_i = 0, acc_store_i = 0;
  logic acc_user_i = 0, acc_hyp_regime_i = 0, acc_high_range_i = 0, acc_tlb_miss_i = 0;
  logic acc_would_fault_i = 0, sys_tx_allowed_i = 0, acc_af_needed_i = 0, acc_dirty_needed_i = 0;
  logic acc_normal_i = 0, acc_inner_share_i = 0, acc_outer_share_i = 0, acc_inner_wb_i = 0;
  logic acc_outer_wb_i = 0, acc_read_alloc_i = 0, acc_write_alloc_i = 0, acc_transient_i = 0;
  logic [15:0] cur_address_space_id_i = 16'h0000, cur_virtual_machine_id_i = 16'h0000, inv_address_space_id_i, inv_virtual_machine_id_i;
  logic [15:0] rq_as = 16'h0000;
  logic [35:0] acc_page_i = '0, inv_page_i, rq_pg = '0;
  logic inv_valid_i, inv_all_i;
  logic [31:0] q_cause[$], q_dest[$], q_rd[$];
  logic [3:0] q_acc[$];
  logic [3:0] e;
  int err_total = 0, check_count = 0;
  localparam logic [7:0] BAD_AT [5] = '{8'h00, 8'hDF, 8'h5E, 8'h9E, 8'hDC};

  transactional_access_checker u_transactional_access_checker (.*);
  tac_remote_pe u_tac_remote_pe (.clk_i(clk_i), .rq_i(rq), .rq_all_i(rq_all),
    .rq_page_i(rq_pg), .rq_address_space_id_i(rq_as), .rq_virtual_machine_id_i(cur_virtual_machine_id_i), .inv_valid_o(inv_valid_i),
    .inv_all_o(inv_all_i), .inv_page_o(inv_page_i), .inv_address_space_id_o(inv_address_space_id_i),
    .inv_virtual_machine_id_o(inv_virtual_machine_id_i));

  always #10 clk_i = ~clk_i;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
    begin
      @(posedge clk_i);
    end
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    q_rd.push_back(exp);
    wb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic tx(input logic [2:0] c);
    {tx_cancel_i, tx_commit_i, tx_start_i} <= c;
    @(posedge clk_i);
    {tx_cancel_i, tx_commit_i, tx_start_i} <= 3'b000;
    @(posedge clk_i);
  endtask : tx

  task automatic acc(input logic [7:0] at, input logic [4:0] m, input logic [35:0] pg,
                     input logic [3:0] ex, input logic [31:0] cz, input logic [31:0] dv);
    {acc_normal_i, acc_inner_share_i, acc_outer_share_i, acc_inner_wb_i, acc_outer_wb_i,
      acc_read_alloc_i, acc_write_alloc_i, acc_transient_i} <= at;
    {acc_store_i, acc_user_i, acc_hyp_regime_i, acc_high_range_i, acc_would_fault_i} <= m;
    {acc_valid_i, acc_tlb_miss_i, acc_af_needed_i, acc_dirty_needed_i} <= {3'b111, m[4]};
    acc_page_i <= pg;
    q_acc.push_back(ex);
    if (cz != 0)
    begin
      q_cause.push_back(cz);
      q_dest.push_back(dv);
    end
    @(posedge clk_i);
    acc_valid_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : acc

  task automatic inv(input logic [35:0] p, input logic al, input logic mt, input logic mem);
    {rq, rq_all, rq_pg, rq_as} <= {1'b1, al, p, mt ? cur_address_space_id_i : ~cur_address_space_id_i};
    if (mem)
    begin
      q_cause.push_back(CAUSE_MEM);
      q_dest.push_back(32'h0002_8000);
    end
    @(posedge clk_i);
    rq <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : inv

  always @(posedge clk_i)
  begin
    if (!rst_i)
    begin
      if (fail_o === 1'b1)
      begin
        check(fail_cause_o, q_cause.size() ? q_cause.pop_front() : 32'h0000_0000);
        check(store_discard_o, 1'b1);
      end
      if (tx_active_o === 1'b1 && (tx_commit_i || tx_cancel_i))
        check({store_release_o, store_discard_o}, {tx_commit_i, tx_cancel_i});
      if (dest_wr_o === 1'b1)
        check(dest_val_o, q_dest.size() ? q_dest.pop_front() : 32'hFFFF_FFFF);
      if (wb_ack_o === 1'b1 && !wb_we_i)
        check(wb_dat_o, q_rd.pop_front());
      if (acc_valid_i)
      begin
        e = q_acc.pop_front();
        check(walk_ok_o, e[2]);
        if (e[3])
          check({af_update_o, dirty_update_o}, e[1:0]);
      end
    end
  end

  initial
  begin
    #400000;
    err_total++;
    tally_and_finish();
  end

  initial
  begin
    logic [35:0] pg;
    void'($urandom(31704));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    {cur_address_space_id_i, cur_virtual_machine_id_i} <= $urandom();
    pg = {4'h1, $urandom()};
    rd(CTRL_OFF, CTRL_RST);
    rd(IRQ_MASK_OFF, IRQ_MASK_RST);
    rd(8'h40, 32'h0000_0000);
    wb(1'b1, IRQ_MASK_OFF, 32'h0000_000F);
    tx(3'b001);
    acc(8'hDE, 5'b00000, pg, 4'b1110, 0, 0);
    acc(8'hBE, 5'b10000, pg + 1, 4'b1111, 0, 0);
    tx(3'b010);
    sys_tx_allowed_i <= 1'b1;
    tx(3'b001);
    acc(8'h00, 5'b00000, pg, 4'b1110, 0, 0);
    tx(3'b010);
    sys_tx_allowed_i <= 1'b0;
    // unsupported types fail, access flag still set
    for (int k = 0; k < 5; k++)
    begin
      tx(3'b001);
      acc(BAD_AT[k], 5'b00000, pg, 4'b1110, CAUSE_IMP, 32'h0100_0000);
    end
    check(irq_o, 1'b1);
    rd(IRQ_STAT_OFF, 32'h0000_0002);
    rd(STATUS_OFF, 32'h0000_0002);
    wb(1'b1, IRQ_STAT_OFF, 32'h0000_000F);
    check(irq_o, 1'b0);
    // each walk-disable bit blocks only its own base
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, CTRL_OFF, 32'h0000_00F0 | (32'h1 << i));
      for (int j = 0; j < 4; j++)
      begin
        tx(3'b001);
        acc(8'hDE, {2'b01, j[1], j[0], i == j}, pg, (i == j) ? 4'b0000 : 4'b1110,
            (i == j) ? CAUSE_ERR : CAUSE_NONE, 32'h0010_0000);
        if (i != j)
          tx(3'b010);
      end
    end
    // only a matching tracked page with own ids fails
    tx(3'b001);
    acc(8'hDE, 5'b00000, pg, 4'b1110, 0, 0);
    inv(pg + 5, 1'b0, 1'b1, 1'b0);
    inv(pg, 1'b0, 1'b0, 1'b0);
    inv(pg, 1'b0, 1'b1, 1'b1);
    // ninth mapping overflows, dirty update kept
    tx(3'b001);
    for (int k = 0; k < 8; k++)
      acc(8'hDE, 5'b00000, pg + k, 4'b1110, 0, 0);
    acc(8'hDE, 5'b10000, pg + 8, 4'b1111, CAUSE_IMP, 32'h0100_0000);
    // untracked mode fails on an untracked page
    wb(1'b1, CTRL_OFF, 32'h0000_00E8);
    tx(3'b001);
    acc(8'hDE, 5'b00000, pg, 4'b1110, 0, 0);
    inv(pg + 9, 1'b0, 1'b1, 1'b1);
    // no flag updates when hardware management is off
    wb(1'b1, CTRL_OFF, 32'h0000_0028);
    tx(3'b001);
    acc(8'hDE, 5'b10000, pg, 4'b1100, 0, 0);
    tx(3'b100);
    // Reset in mid-run restores register defaults
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CTRL_OFF, CTRL_RST);
    rd(IRQ_STAT_OFF, 32'h0000_0000);
    check(irq_o, 1'b0);
    check(tx_active_o, 1'b0);
    check(q_cause.size(), 0);
    check(q_dest.size(), 0);
    tally_and_finish();
  end
endmodule : transactional_access_checker_tb

bind transactional_access_checker tac_monitor u_tac_monitor (.*);
`default_nettype wire
